//--- twdma_map.vh
`ifndef TWDMA_MAP_VH
`define TWDMA_MAP_VH
`define TWDMA_CLK_PERIOD_PS   32'd5000
`define TWDMA_PHASE_NS        32'd80
`define TWDMA_PHASE_CYC       (((`TWDMA_PHASE_NS * 32'd1000) + `TWDMA_CLK_PERIOD_PS - 32'd1) / `TWDMA_CLK_PERIOD_PS)
`define TWDMA_LOW_MAX_NS      32'd7000
`define TWDMA_LOW_MAX_CYC     ((`TWDMA_LOW_MAX_NS * 32'd1000) / `TWDMA_CLK_PERIOD_PS)
`define TWDMA_CNT_W           8
`define TWDMA_LEN_W           5
`define TWDMA_DATA_W          20
// command codes
`define TWDMA_CMD_TMS         3'h0
`define TWDMA_CMD_IR          3'h1
`define TWDMA_CMD_DR          3'h2
`define TWDMA_CMD_SET_TARGET_CPU_CLOCK    3'h3
`define TWDMA_CMD_CLR_TARGET_CPU_CLOCK    3'h4
// instruction codes
`define TWDMA_SET_ADDRESS_INSTR      8'h83
`define TWDMA_READ_ADDRESS_INSTR     8'h84
`define TWDMA_WRITE_AT_ADDRESS_INSTR 8'h85
`define TWDMA_WORD_DATA_INSTR        8'h41
`define TWDMA_FAST_SEQ_DATA_INSTR    8'h43
`define TWDMA_PASSTHROUGH_INSTR      8'hFF
`define TWDMA_CTRL_ACCESS_INSTR      8'h13
`define TWDMA_CTRL_CAPTURE_INSTR     8'h14
`define TWDMA_CTRL_RELEASE_INSTR     8'h15
`define TWDMA_SIG_DATA_INSTR         8'h44
`define TWDMA_SIG_OUT_INSTR          8'h46
`define TWDMA_FUSE_PREPARE_INSTR     8'h22
`define TWDMA_FUSE_EXECUTE_INSTR     8'h24
`define TWDMA_MAILBOX_SWAP_INSTR     8'h61
`define TWDMA_IR_LEN          5'd8
`define TWDMA_ADDR_LEN        5'd20
`define TWDMA_WORD_LEN        5'd16
`endif

//--- twdma_slot.v
`timescale 1ns/1ps
`include "twdma_map.vh"
// one time slot: set data, clock low, sample, clock high
module twdma_slot
(
   input  wire       core_clk,
   input  wire       rstn,
   input  wire       start,
   input  wire       dataBit,
   input  wire       floatData,
   input  wire       lateHigh,
   input  wire       lineIn,
   output reg        clkOut_q,
   output reg        dataOut_q,
   output reg        dataOe_q,
   output reg        sample_q,
   output reg        done_q
);
   localparam [3:0] S_IDLE = 4'b0001;
   localparam [3:0] S_SET  = 4'b0010;
   localparam [3:0] S_LOW  = 4'b0100;
   localparam [3:0] S_HIGH = 4'b1000;
   reg [3:0]              state_q;
   reg [`TWDMA_CNT_W-1:0] cnt_q;
   reg                    float_q;
   reg                    late_q;
   wire cntDone = (cnt_q == {`TWDMA_CNT_W{1'b0}});
   localparam [31:0] PHASE_FULL = `TWDMA_PHASE_CYC;
   wire [`TWDMA_CNT_W-1:0] phaseCyc = PHASE_FULL[`TWDMA_CNT_W-1:0];
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q   <= S_IDLE;
         cnt_q     <= {`TWDMA_CNT_W{1'b0}};
         clkOut_q  <= 1'b1;
         dataOut_q <= 1'b0;
         dataOe_q  <= 1'b1;
         sample_q  <= 1'b0;
         done_q    <= 1'b0;
         float_q   <= 1'b0;
         late_q    <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         case (state_q)
            S_IDLE:
               if (start)
               begin
                  float_q <= floatData;
                  late_q  <= lateHigh;
                  cnt_q   <= phaseCyc;
                  if (floatData)
                     dataOe_q <= 1'b0;
                  else
                     dataOut_q <= dataBit;
                  state_q <= S_SET;
               end
               else
                  dataOe_q <= 1'b1; // redrive after clock high
            S_SET:
               if (cntDone)
               begin
                  clkOut_q <= 1'b0;
                  cnt_q    <= phaseCyc;
                  state_q  <= S_LOW;
               end
               else
                  cnt_q <= cnt_q - 1'b1;
            S_LOW:
               if (cntDone)
               begin
                  if (float_q)
                     sample_q <= lineIn;
                  if (late_q)
                     dataOut_q <= 1'b1;
                  cnt_q   <= phaseCyc;
                  state_q <= S_HIGH;
               end
               else
                  cnt_q <= cnt_q - 1'b1;
            S_HIGH:
            begin
               clkOut_q <= 1'b1; // far end releases here
               done_q   <= 1'b1;
               state_q  <= S_IDLE;
            end
            default:
               state_q <= S_IDLE;
         endcase
      end
   end
endmodule // twdma_slot

//--- twdma_host.v
`timescale 1ns/1ps
`include "twdma_map.vh"
// programmer: turns commands into slot triplets on the two-wire link
module twdma_host
(
   input  wire                     core_clk,
   input  wire                     rstn,
   input  wire                     cmdValid,
   input  wire [2:0]               cmdCode,
   input  wire [`TWDMA_DATA_W-1:0] cmdData,
   input  wire [`TWDMA_LEN_W-1:0]  cmdLen,
   input  wire                     cmdTms,
   input  wire                     twoWireDataIn,
   output reg                      cmdReady_q,
   output reg                      rspValid_q,
   output reg  [`TWDMA_DATA_W-1:0] rspData_q,
   output reg                      twoWireClk_q,
   output reg                      twoWireDataOut_q,
   output reg                      twoWireDataOe_q,
   output reg                      targetClk_q
);
   ////////////////////////////////////////////////////////////////////////
   localparam [7:0] M_IDLE  = 8'b00000001;
   localparam [7:0] M_LOAD  = 8'b00000010;
   localparam [7:0] M_TMS   = 8'b00000100;
   localparam [7:0] M_TDI   = 8'b00001000;
   localparam [7:0] M_TDO   = 8'b00010000;
   localparam [7:0] M_NEXT  = 8'b00100000;
   localparam [7:0] M_WAIT  = 8'b01000000;
   localparam [7:0] M_DONE  = 8'b10000000;
   localparam [1:0] N_IR = 2'd0;
   localparam [1:0] N_DR = 2'd1;
   localparam [1:0] N_TK = 2'd2;
   localparam [1:0] N_TM = 2'd3;
   localparam [`TWDMA_DATA_W-1:0] PASS_CODE =
      {{(`TWDMA_DATA_W-8){1'b0}}, `TWDMA_PASSTHROUGH_INSTR};
   reg [7:0]               state_q;
   reg [1:0]               kind_q;
   reg [`TWDMA_DATA_W-1:0] shift_q;
   reg [`TWDMA_DATA_W-1:0] capt_q;
   reg [`TWDMA_LEN_W-1:0]  left_q;
   reg [`TWDMA_LEN_W-1:0]  shLen_q;
   reg [3:0]               hdr_q;
   reg [3:0]               hdrLen_q;
   reg [5:0]               tmsSeq_q;
   reg                     tclkVal_q;
   reg                     tmsOne_q;
   reg                     slotStart_q;
   reg                     slotBit_q;
   reg                     slotFloat_q;
   reg                     slotLate_q;
   reg                     dinMeta_q;
   reg                     dinSync_q;
   wire                    slotClk;
   wire                    slotData;
   wire                    slotOe;
   wire                    slotSample;
   wire                    slotDone;
   ////////////////////////////////////////////////////////////////////////
   // pin input synchroniser
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dinMeta_q <= 1'b0;
         dinSync_q <= 1'b0;
      end
      else
      begin
         dinMeta_q <= twoWireDataIn;
         dinSync_q <= dinMeta_q;
      end
   end
   twdma_slot u_slot
   (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .start     (slotStart_q),
      .dataBit   (slotBit_q),
      .floatData (slotFloat_q),
      .lateHigh  (slotLate_q),
      .lineIn    (dinSync_q),
      .clkOut_q  (slotClk),
      .dataOut_q (slotData),
      .dataOe_q  (slotOe),
      .sample_q  (slotSample),
      .done_q    (slotDone)
   );
   ////////////////////////////////////////////////////////////////////////
   // pins registered again so outputs come from flip-flops
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         twoWireClk_q     <= 1'b1;
         twoWireDataOut_q <= 1'b0;
         twoWireDataOe_q  <= 1'b1;
      end
      else
      begin
         twoWireClk_q     <= slotClk;
         twoWireDataOut_q <= slotData;
         twoWireDataOe_q  <= slotOe;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // header tms sequences from run-test/idle, lsb first:
   // ir: 1,1,0,0 -> shift-ir ; dr: 1,0,0 -> shift-dr
   // trailer: 1 (exit1 on last bit), 1 update, 0 idle
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q     <= M_IDLE;
         kind_q      <= N_IR;
         shift_q     <= {`TWDMA_DATA_W{1'b0}};
         capt_q      <= {`TWDMA_DATA_W{1'b0}};
         left_q      <= {`TWDMA_LEN_W{1'b0}};
         hdr_q       <= 4'h0;
         hdrLen_q    <= 4'h0;
         tmsSeq_q    <= 6'h00;
         tclkVal_q   <= 1'b0;
         tmsOne_q    <= 1'b0;
         slotStart_q <= 1'b0;
         slotBit_q   <= 1'b0;
         slotFloat_q <= 1'b0;
         slotLate_q  <= 1'b0;
         cmdReady_q  <= 1'b1;
         rspValid_q  <= 1'b0;
         rspData_q   <= {`TWDMA_DATA_W{1'b0}};
         targetClk_q <= 1'b0;
      end
      else
      begin
         slotStart_q <= 1'b0;
         rspValid_q  <= 1'b0;
         case (state_q)
            M_IDLE:
               if (cmdValid)
               begin
                  cmdReady_q <= 1'b0;
                  capt_q     <= {`TWDMA_DATA_W{1'b0}};
                  state_q    <= M_LOAD;
                  case (cmdCode)
                     `TWDMA_CMD_IR:
                     begin
                        kind_q   <= N_IR;
                        // undefined codes go out as passthrough
                        if (instrOk(cmdData[7:0]))
                           shift_q <= cmdData; // lsb first
                        else
                           shift_q <= PASS_CODE;
                        left_q   <= `TWDMA_IR_LEN;
                        tmsSeq_q <= 6'h03;
                        hdrLen_q <= 4'h4;
                     end
                     `TWDMA_CMD_DR:
                     begin
                        kind_q   <= N_DR;
                        // msb first: reverse into lsb-first shifter
                        shift_q  <= revBits(cmdData, cmdLen);
                        left_q   <= cmdLen;
                        tmsSeq_q <= 6'h01;
                        hdrLen_q <= 4'h3;
                     end
                     `TWDMA_CMD_SET_TARGET_CPU_CLOCK,
                     `TWDMA_CMD_CLR_TARGET_CPU_CLOCK:
                     begin
                        kind_q    <= N_TK;
                        tclkVal_q <= (cmdCode == `TWDMA_CMD_SET_TARGET_CPU_CLOCK);
                        left_q    <= {`TWDMA_LEN_W{1'b0}};
                        hdrLen_q  <= 4'h0;
                     end
                     default:
                     begin
                        kind_q   <= N_TM;
                        tmsOne_q <= cmdTms;
                        left_q   <= {`TWDMA_LEN_W{1'b0}};
                        hdrLen_q <= 4'h0;
                     end
                  endcase
                  hdr_q <= 4'h0;
               end
            M_LOAD:
            begin
               // control slot of the next triplet
               state_q     <= M_TMS;
               slotStart_q <= 1'b1;
               slotFloat_q <= 1'b0;
               slotLate_q  <= 1'b0;
               if (kind_q == N_TK)
               begin
                  slotBit_q <= 1'b0;
                  // clear needs line high before data-in slot
                  slotLate_q <= ~tclkVal_q;
               end
               else if (kind_q == N_TM)
                  slotBit_q <= tmsOne_q;
               else if (hdr_q < hdrLen_q)
                  slotBit_q <= tmsSeq_q[hdr_q[2:0]];
               else if (left_q == 5'd1)
                  slotBit_q <= 1'b1;
               else if (left_q == 5'd0)
                  slotBit_q <= (hdr_q == hdrLen_q) ? 1'b1 : 1'b0;
               else
                  slotBit_q <= 1'b0;
            end
            M_TMS:
               if (slotDone)
               begin
                  state_q     <= M_TDI;
                  slotStart_q <= 1'b1;
                  slotLate_q  <= 1'b0;
                  if (kind_q == N_TK)
                     slotBit_q <= tclkVal_q;
                  else if (kind_q == N_TM)
                     slotBit_q <= targetClk_q; // keep target clock level
                  else if (hdr_q >= hdrLen_q && left_q != 5'd0)
                     slotBit_q <= shift_q[0];
                  else
                     slotBit_q <= targetClk_q;
               end
            M_TDI:
               if (slotDone)
               begin
                  state_q     <= M_TDO;
                  slotStart_q <= 1'b1;
                  slotFloat_q <= 1'b1;
                  if (kind_q == N_TK)
                     targetClk_q <= tclkVal_q; // one edge
               end
            M_TDO:
               if (slotDone)
                  state_q <= M_NEXT;
            M_NEXT:
            begin
               state_q <= M_LOAD;
               if (kind_q == N_TK || kind_q == N_TM)
                  state_q <= M_DONE;
               else if (hdr_q < hdrLen_q)
                  hdr_q <= hdr_q + 4'h1;
               else if (left_q != 5'd0)
               begin
                  // serial test output of this shift bit
                  capt_q  <= {slotSample, capt_q[`TWDMA_DATA_W-1:1]};
                  shift_q <= {1'b0, shift_q[`TWDMA_DATA_W-1:1]};
                  left_q  <= left_q - 5'd1;
               end
               else if (hdr_q == hdrLen_q + 4'h1)
                  state_q <= M_WAIT; // back in run-test/idle
               else
                  hdr_q <= hdr_q + 4'h1;
            end
            M_WAIT:
            begin
               rspData_q <= (kind_q == N_IR) ? capt_q >> 12 :
                            revOut(capt_q, (kind_q == N_DR) ? shLen_q : 5'd0);
               state_q   <= M_DONE;
            end
            M_DONE:
            begin
               rspValid_q <= 1'b1;
               cmdReady_q <= 1'b1;
               state_q    <= M_IDLE;
            end
            default:
               state_q <= M_IDLE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // shift length kept for realigning the reply
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         shLen_q <= {`TWDMA_LEN_W{1'b0}};
      else if (state_q == M_IDLE && cmdValid)
         shLen_q <= cmdLen;
   end
   function [`TWDMA_DATA_W-1:0] revBits;
      input [`TWDMA_DATA_W-1:0] v;
      input [`TWDMA_LEN_W-1:0]  n;
      integer i;
      begin
         revBits = {`TWDMA_DATA_W{1'b0}};
         for (i = 0; i < `TWDMA_DATA_W; i = i + 1)
            if (i < n)
               revBits[i] = v[n - 1 - i];
      end
   endfunction
   // captured bits arrive msb first in top bits; realign to value
   function [`TWDMA_DATA_W-1:0] revOut;
      input [`TWDMA_DATA_W-1:0] v;
      input [`TWDMA_LEN_W-1:0]  n;
      integer i;
      begin
         revOut = {`TWDMA_DATA_W{1'b0}};
         for (i = 0; i < `TWDMA_DATA_W; i = i + 1)
            if (i < n)
               revOut[n - 1 - i] = v[`TWDMA_DATA_W - n + i];
      end
   endfunction
   // defined instruction set
   function instrOk;
      input [7:0] c;
      begin
         case (c)
            `TWDMA_SET_ADDRESS_INSTR,
            `TWDMA_READ_ADDRESS_INSTR,
            `TWDMA_WRITE_AT_ADDRESS_INSTR,
            `TWDMA_WORD_DATA_INSTR,
            `TWDMA_FAST_SEQ_DATA_INSTR,
            `TWDMA_PASSTHROUGH_INSTR,
            `TWDMA_CTRL_ACCESS_INSTR,
            `TWDMA_CTRL_CAPTURE_INSTR,
            `TWDMA_CTRL_RELEASE_INSTR,
            `TWDMA_SIG_DATA_INSTR,
            `TWDMA_SIG_OUT_INSTR,
            `TWDMA_FUSE_PREPARE_INSTR,
            `TWDMA_FUSE_EXECUTE_INSTR,
            `TWDMA_MAILBOX_SWAP_INSTR:
               instrOk = 1'b1;
            default:
               instrOk = 1'b0;
         endcase
      end
   endfunction
endmodule // twdma_host

//--- twdma_chk.sv
`timescale 1ns/1ps
// watches the host ports for link and handshake timing
module twdma_chk
(
   input wire       core_clk,
   input wire       rstn,
   input wire       cmdValid,
   input wire [2:0] cmdCode,
   input wire       cmdReady_q,
   input wire       rspValid_q,
   input wire       twoWireClk_q,
   input wire       twoWireDataOut_q,
   input wire       twoWireDataOe_q,
   input wire       targetClk_q
);
   localparam int LOW_MAX = 1400;
   logic [1:0]  slot_q;
   logic [10:0] lowCnt_q;
   logic [2:0]  code_q;
   wire         tclkCmd;

   assign tclkCmd = !cmdReady_q && (code_q == 3'h3 || code_q == 3'h4);

   ////////////////////////////////////////////////////////////////////////
   // slot index advances one cycle after each rising link clock
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         slot_q <= 2'h0;
         lowCnt_q <= 11'h000;
         code_q <= 3'h0;
      end
      else
      begin
         if ($rose(twoWireClk_q))
            slot_q <= (slot_q == 2'h2) ? 2'h0 : slot_q + 2'h1;
         lowCnt_q <= twoWireClk_q ? 11'h000 : lowCnt_q + 11'h001;
         if (cmdValid && cmdReady_q)
            code_q <= cmdCode;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   out_float_a: assert property (
      !twoWireClk_q && slot_q == 2'h2 |-> !twoWireDataOe_q)
      else $error("host drives line in output slot");
   redrive_high_a: assert property (
      $rose(twoWireDataOe_q) |-> twoWireClk_q && $past(twoWireClk_q))
      else $error("host redrives line while clock low");
   ctrl_hold_a: assert property (
      $fell(twoWireClk_q) && slot_q == 2'h0 && tclkCmd |-> !twoWireDataOut_q)
      else $error("control slot not low in target clock command");
   raise_low_a: assert property (
      tclkCmd && slot_q == 2'h0 && twoWireDataOe_q && $past(twoWireDataOe_q)
      && !$rose(twoWireClk_q) && $rose(twoWireDataOut_q) |-> !twoWireClk_q)
      else $error("line raised in control slot with clock high");
   low_phase_a: assert property (
      $rose(twoWireClk_q) |-> lowCnt_q >= 11'd16)
      else $error("link clock low phase too short");
   low_limit_a: assert property (
      lowCnt_q < LOW_MAX)
      else $error("link clock low phase over limit");
   target_cpu_clock_only_a: assert property (
      $changed(targetClk_q) |-> tclkCmd || $past(tclkCmd))
      else $error("target clock moved outside its commands");
   rsp_pulse_a: assert property (
      rspValid_q |=> !rspValid_q)
      else $error("response pulse longer than one cycle");
   ready_drop_a: assert property (
      cmdValid && cmdReady_q |=> !cmdReady_q ##1 !cmdReady_q)
      else $error("ready not dropped after accept");
   idle_level_a: assert property (
      cmdReady_q && !rspValid_q |-> twoWireClk_q && twoWireDataOe_q)
      else $error("link not idle while ready");

   cover property (rspValid_q && code_q == 3'h3);
   cover property (rspValid_q && code_q == 3'h4);
   cover property (rspValid_q && code_q == 3'h2);
endmodule // twdma_chk

//--- twdma_dev_model.sv
`timescale 1ns/1ps
// device end of the link: tap, instruction and data registers
module twdma_dev_model
#(
   parameter [7:0] IR_CAP = 8'h5A // arbitrary capture pattern
)
(
   input  wire rstn,
   input  wire twoWireClk,
   input  wire lineLvl,
   output reg  devOut,
   output wire devOe,
   output reg  targetClk
);
   localparam [63:0] NEXT0 = 64'h1BDDBBA146644311;
   localparam [63:0] NEXT1 = 64'h2FEFCC0287855920;
   reg [1:0]  slotQ;
   reg        tmsQ;
   reg        drvQ;
   reg        tdoQ;
   reg [3:0]  tapQ;
   reg [7:0]  irQ;
   reg [7:0]  irSr;
   reg [19:0] drSr;
   reg [19:0] addrQ;
   reg [15:0] dataQ;
   wire       isAddr;

   assign isAddr = irQ == 8'h83 || irQ == 8'h84;
   assign devOe = drvQ & ~twoWireClk;

   ////////////////////////////////////////////////////////////////////////
   always @(negedge twoWireClk or negedge rstn)
   begin
      if (!rstn)
      begin
         slotQ = 2'h0;
         tmsQ = 1'b0;
         drvQ = 1'b0;
         tdoQ = 1'b0;
         tapQ = 4'h1;
         irQ = 8'hFF;
         irSr = 8'h00;
         drSr = 20'h00000;
         addrQ = 20'h00000;
         dataQ = 16'h0000;
         devOut = 1'b0;
         targetClk = 1'b0;
      end
      else
      begin
         drvQ = slotQ == 2'h2;
         if (slotQ == 2'h0)
            tmsQ = lineLvl;
         else if (slotQ == 2'h1)
         begin
            case (tapQ)
               4'h1: targetClk = lineLvl;
               4'h3: drSr = isAddr ? addrQ : {dataQ, 4'h0};
               4'h4:
               begin
                  tdoQ = drSr[19];
                  drSr = {drSr[18:0], lineLvl};
               end
               4'h8:
                  if (irQ == 8'h83)
                     addrQ = drSr;
                  else if (!isAddr && irQ != 8'hFF)
                     dataQ = drSr[15:0];
               4'hA: irSr = IR_CAP;
               4'hB:
               begin
                  tdoQ = irSr[0];
                  irSr = {lineLvl, irSr[7:1]};
               end
               4'hF: irQ = irSr;
               default: ;
            endcase
            tapQ = tmsQ ? NEXT1[tapQ*4 +: 4] : NEXT0[tapQ*4 +: 4];
         end
         devOut = tdoQ;
         slotQ = (slotQ == 2'h2) ? 2'h0 : slotQ + 2'h1;
      end
   end
endmodule // twdma_dev_model

//--- twdma_host_tb_top.sv
`timescale 1ns/1ps
`include "twdma_map.vh"
module twdma_host_tb_top;
   reg         core_clk;
   reg         rstn;
   reg         cmdValid;
   reg  [2:0]  cmdCode;
   reg  [19:0] cmdData;
   reg  [4:0]  cmdLen;
   reg         cmdTms;
   reg         keepQ;
   reg         clash;
   reg  [19:0] rsp;
   reg  [19:0] v;
   reg  [19:0] expAddr;
   reg  [15:0] expData;
   reg  [7:0]  codes [0:13];
   integer     err_count;
   integer     checks;
   integer     cyc;
   integer     i;
   wire        cmdReady_q;
   wire        rspValid_q;
   wire [19:0] rspData_q;
   wire        twoWireClk_q;
   wire        twoWireDataOut_q;
   wire        twoWireDataOe_q;
   wire        targetClk_q;
   wire        lineLvl;
   wire        devOut;
   wire        devOe;
   wire        devClk;

   // undriven line shows the inverse of its last driven level
   assign lineLvl = twoWireDataOe_q ? twoWireDataOut_q
                                    : (devOe ? devOut : ~keepQ);

   twdma_host u_dut
   (
      .core_clk(core_clk), .rstn(rstn), .cmdValid(cmdValid),
      .cmdCode(cmdCode), .cmdData(cmdData), .cmdLen(cmdLen),
      .cmdTms(cmdTms), .twoWireDataIn(lineLvl), .cmdReady_q(cmdReady_q),
      .rspValid_q(rspValid_q), .rspData_q(rspData_q),
      .twoWireClk_q(twoWireClk_q), .twoWireDataOut_q(twoWireDataOut_q),
      .twoWireDataOe_q(twoWireDataOe_q), .targetClk_q(targetClk_q)
   );

   twdma_dev_model u_dev
   (
      .rstn(rstn), .twoWireClk(twoWireClk_q), .lineLvl(lineLvl),
      .devOut(devOut), .devOe(devOe), .targetClk(devClk)
   );

   ////////////////////////////////////////////////////////////////////////
   always #2.5 core_clk = ~core_clk;

   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (twoWireDataOe_q | devOe)
         keepQ <= lineLvl;
      if (twoWireDataOe_q & devOe)
         clash <= 1'b1;
      if (cyc == 90000)
      begin
         err_count = err_count + 1;
         complete_run;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task chk(input string name, input [19:0] exp, input [19:0] got);
      begin
         checks = checks + 1;
         if (got !== exp)
         begin
            $display("Error %0s expected %h seen %h", name, exp, got);
            err_count = err_count + 1;
         end
      end
   endtask

   task issue(input [2:0] c, input [19:0] d, input [4:0] n, input t);
      integer k;
      begin
         cmdCode <= c;
         cmdData <= d;
         cmdLen <= n;
         cmdTms <= t;
         cmdValid <= 1'b1;
         @(posedge core_clk);
         cmdValid <= 1'b0;
         k = 0;
         @(negedge core_clk);
         while (rspValid_q !== 1'b1 && k < 5000)
         begin
            @(negedge core_clk);
            k = k + 1;
         end
         chk("rspValid", 20'h1, {19'h0, rspValid_q});
         rsp = rspData_q;
         @(posedge core_clk);
      end
   endtask

   task complete_run;
      begin
         $display("checks %0d mismatches %0d", checks, err_count);
         if (err_count == 0 && checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      rstn = 1'b0;
      cmdValid = 1'b0;
      cmdCode = 3'h0;
      cmdData = 20'h00000;
      cmdLen = 5'h00;
      cmdTms = 1'b0;
      keepQ = 1'b0;
      clash = 1'b0;
      err_count = 0;
      checks = 0;
      cyc = 0;
      expAddr = 20'h00000;
      expData = 16'h0000;
      codes = '{8'h83, 8'h84, 8'h85, 8'h41, 8'h43, 8'hFF, 8'h13, 8'h14,
                8'h15, 8'h44, 8'h46, 8'h22, 8'h24, 8'h61};
      v = $urandom(32'hBC0B);
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      for (i = 0; i < 5; i = i + 1)
         issue(3'h0, 20'h0, 5'h0, 1'b1);
      issue(3'h0, 20'h0, 5'h0, 1'b0);
      chk("tap state", 20'h1, {16'h0, u_dev.tapQ});
      $display("tap walk done");
      for (i = 0; i < 14; i = i + 1)
      begin
         issue(3'h1, {12'h0, codes[i]}, 5'd8, 1'b0);
         chk("instr", {12'h0, codes[i]}, {12'h0, u_dev.irQ});
         chk("ir capture", 20'h5A, {12'h0, rsp[7:0]});
      end
      issue(3'h1, 20'h00000, 5'd8, 1'b0);
      chk("undef instr", 20'hFF, {12'h0, u_dev.irQ});
      $display("instruction test done");
      issue(3'h1, 20'h83, 5'd8, 1'b0);
      for (i = 0; i < 3; i = i + 1)
      begin
         v = $urandom;
         issue(3'h2, v, 5'd20, 1'b0);
         chk("addr out", expAddr, rsp);
         expAddr = v;
         chk("addr reg", expAddr, u_dev.addrQ);
      end
      issue(3'h1, 20'h84, 5'd8, 1'b0);
      issue(3'h2, $urandom, 5'd20, 1'b0);
      chk("addr capture", expAddr, rsp);
      chk("addr kept", expAddr, u_dev.addrQ);
      $display("address test done");
      for (i = 3; i < 6; i = i + 1)
      begin
         issue(3'h1, {12'h0, codes[i - 1]}, 5'd8, 1'b0);
         v = $urandom;
         issue(3'h2, {4'h0, v[15:0]}, 5'd16, 1'b0);
         chk("data out", {4'h0, expData}, {4'h0, rsp[15:0]});
         expData = v[15:0];
         chk("data reg", {4'h0, expData}, {4'h0, u_dev.dataQ});
      end
      $display("data test done");
      for (i = 0; i < 6; i = i + 1)
      begin
         v = $urandom;
         if (i < 2)
            v[0] = i[0];
         issue(v[0] ? 3'h3 : 3'h4, 20'h0, 5'h0, 1'b0);
         chk("target clk", {19'h0, v[0]}, {19'h0, devClk});
         chk("clk copy", {19'h0, v[0]}, {19'h0, targetClk_q});
         chk("tap idle", 20'h1, {16'h0, u_dev.tapQ});
      end
      chk("line clash", 20'h0, {19'h0, clash});
      $display("target clock test done");
      complete_run;
   end
endmodule // twdma_host_tb_top

bind twdma_host twdma_chk u_chk
(
   .core_clk(core_clk), .rstn(rstn), .cmdValid(cmdValid),
   .cmdCode(cmdCode), .cmdReady_q(cmdReady_q), .rspValid_q(rspValid_q),
   .twoWireClk_q(twoWireClk_q), .twoWireDataOut_q(twoWireDataOut_q),
   .twoWireDataOe_q(twoWireDataOe_q), .targetClk_q(targetClk_q)
);
